// [verilog/supervisor_reset_watchdog.sv]
/*
 * reset supervisor: combines supply, auxiliary, manual and watchdog causes
 * into two stretched active-low resets and a power-fail flag.
 * assumes comparator flags and pin-sense inputs are asynchronous to ref_clk_i;
 * all of them pass a two-stage synchroniser first.
 */
`timescale 1ns/100ps
`include "supervisor_defs.svh"
module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter logic [`CNT_W-1:0] RST_TIMEOUT_CYC = `CNT_W'(`RST_TIMEOUT_CYC),
  parameter logic [`CNT_W-1:0] WD_LONG_CYC = `CNT_W'(`WD_LONG_CYC),
  parameter logic [`CNT_W-1:0] WD_SHORT_CYC = `CNT_W'(`WD_SHORT_CYC)
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // comparator flags, high while below threshold
  input wire logic primary_uv_i,
  input wire logic secondary_uv_i,
  input wire logic aux_undervoltage_in_i,
  input wire logic power_fail_in_i,
  // manual reset and its pad-sense: connected is low when pin floats
  input wire logic manual_reset_n_i,
  input wire logic manual_reset_conn_i,
  // watchdog kick and its pad-sense: connected is low when pin floats
  input wire logic watchdog_kick_in_i,
  input wire logic watchdog_conn_i,
  // outputs
  output logic primary_reset_n_o,
  output logic secondary_reset_n_o,
  output logic power_fail_out_n_o
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  assign raw = {primary_uv_i, secondary_uv_i, aux_undervoltage_in_i, power_fail_in_i,
                manual_reset_n_i | ~manual_reset_conn_i, watchdog_kick_in_i, watchdog_conn_i};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  cause_t c;
  logic kick;
  logic wd_en;
  // whole struct from one assignment, so it has a single driver
  assign c = '{primary_uv: sync_r[6],
               secondary_uv: sync_r[5],
               aux_uv: sync_r[4],
               manual_reset_n: sync_r[2],
               power_fail: sync_r[3]};
  assign kick = sync_r[1];
  assign wd_en = sync_r[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sup_state_t s_r;
  sup_state_t s_nxt;
  logic sec_cause;
  logic pri_cause;
  logic kick_edge;
  logic [`CNT_W-1:0] wd_limit;

  // stretch counter step: cause restarts from zero, else count to timeout
  function automatic logic [`CNT_W-1:0] stretch(input logic cause,
                                                input logic [`CNT_W-1:0] cnt);
    if (cause) begin
      stretch = '0;
    end else if (cnt < RST_TIMEOUT_CYC) begin
      stretch = cnt + `CNT_W'(1);
    end else begin
      stretch = cnt;
    end
  endfunction

  always_comb begin
    sec_cause = c.primary_uv | c.secondary_uv | ~c.manual_reset_n;
    pri_cause = sec_cause | c.aux_uv | s_r.wd_fire;
    kick_edge = kick ^ s_r.kick_prev;
    wd_limit = s_r.wd_short ? WD_SHORT_CYC : WD_LONG_CYC;
    s_nxt = s_r;
    s_nxt.kick_prev = kick;
    s_nxt.pri_cnt = stretch(pri_cause, s_r.pri_cnt);
    s_nxt.sec_cnt = stretch(sec_cause, s_r.sec_cnt);
    // reset released only once the full timeout has elapsed cause-free
    s_nxt.primary_reset_n = ~pri_cause && (s_nxt.pri_cnt >= RST_TIMEOUT_CYC);
    s_nxt.secondary_reset_n = ~sec_cause && (s_nxt.sec_cnt >= RST_TIMEOUT_CYC);
    s_nxt.power_fail_out_n = ~c.power_fail;
    s_nxt.wd_fire = 1'b0;
    if (!s_r.primary_reset_n || !wd_en) begin
      // held in reset: timer cleared, long mode rearmed
      s_nxt.wd_cnt = '0;
      s_nxt.wd_short = 1'b0;
    end else if (kick_edge) begin
      s_nxt.wd_cnt = '0;
      s_nxt.wd_short = 1'b1;
    end else if (s_r.wd_cnt + `CNT_W'(1) >= wd_limit) begin
      s_nxt.wd_fire = 1'b1;
      s_nxt.wd_cnt = '0;
    end else begin
      s_nxt.wd_cnt = s_r.wd_cnt + `CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_r <= '{pri_cnt: '0, sec_cnt: '0, wd_cnt: '0, primary_reset_n: 1'b0,
               secondary_reset_n: 1'b0, power_fail_out_n: 1'b1, wd_short: 1'b0,
               kick_prev: 1'b0, wd_fire: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign primary_reset_n_o = s_r.primary_reset_n;
  assign secondary_reset_n_o = s_r.secondary_reset_n;
  assign power_fail_out_n_o = s_r.power_fail_out_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sec_assert_a: assert property (sec_cause |=> !secondary_reset_n_o)
    else $error("secondary reset not asserted on cause");
  pri_assert_a: assert property (pri_cause |=> !primary_reset_n_o)
    else $error("primary reset not asserted on cause");
  sec_ignores_aux_a: assert property (c.aux_uv && !sec_cause && secondary_reset_n_o
                                      |=> secondary_reset_n_o)
    else $error("secondary reset reacted to aux flag");
  pri_release_a: assert property ($rose(primary_reset_n_o) |->
                                  s_r.pri_cnt >= RST_TIMEOUT_CYC)
    else $error("primary reset released before timeout");
  sec_restart_a: assert property (sec_cause |=> s_r.sec_cnt == '0)
    else $error("secondary stretch not restarted");
  pfo_follow_a: assert property (c.power_fail |=> !power_fail_out_n_o)
    else $error("power-fail output not asserted");
  pfo_release_a: assert property (!c.power_fail |=> power_fail_out_n_o)
    else $error("power-fail output stretched");
  wd_clear_a: assert property (primary_reset_n_o && wd_en && kick_edge
                               |=> s_r.wd_cnt == '0 && s_r.wd_short)
    else $error("watchdog not cleared on kick");
  wd_fire_a: assert property (s_r.wd_fire |=> !primary_reset_n_o)
    else $error("watchdog expiry did not reset");
  wd_off_a: assert property (!wd_en |=> !s_r.wd_fire)
    else $error("watchdog fired while disabled");

  // ----------------------------------------------------------------
  // pin-level sequences: three held samples cover both sync stages
  // ----------------------------------------------------------------
  // rst_b_i is part of each pin sequence: a synchroniser flushed at
  // release would otherwise make the first sample look late
  sequence supply_low_s;
    (rst_b_i && (primary_uv_i || secondary_uv_i)) [*3];
  endsequence

  sequence manual_low_s;
    (rst_b_i && !manual_reset_n_i && manual_reset_conn_i) [*3];
  endsequence

  sequence aux_low_s;
    (rst_b_i && aux_undervoltage_in_i) [*3];
  endsequence

  sequence pf_low_s;
    (rst_b_i && power_fail_in_i) [*3];
  endsequence

  sequence pf_high_s;
    (rst_b_i && !power_fail_in_i) [*3];
  endsequence

  sequence both_resets_low_s;
    !primary_reset_n_o && !secondary_reset_n_o;
  endsequence

  sequence wd_expiry_s;
    s_r.wd_fire ##1 !primary_reset_n_o;
  endsequence

  sequence kick_taken_s;
    primary_reset_n_o && wd_en && kick_edge;
  endsequence

  supply_to_pins_a: assert property (supply_low_s |=> both_resets_low_s)
    else $error("supply flag did not reach both resets");
  manual_to_pins_a: assert property (manual_low_s |=> both_resets_low_s)
    else $error("manual reset did not reach both resets");
  aux_to_primary_a: assert property (aux_low_s |=> !primary_reset_n_o)
    else $error("aux flag did not reach primary reset");
  pf_to_pin_a: assert property (pf_low_s |=> !power_fail_out_n_o)
    else $error("power-fail input did not reach its output");
  pf_pin_release_a: assert property (pf_high_s |=> power_fail_out_n_o)
    else $error("power-fail output held after input cleared");
  wd_rearm_long_a: assert property (wd_expiry_s
                                    |=> !s_r.wd_short && s_r.wd_cnt == '0)
    else $error("long watchdog period not rearmed after expiry");
  kick_arm_short_a: assert property (kick_taken_s |=> s_r.wd_short)
    else $error("kick did not select the short period");
  pri_restart_a: assert property (pri_cause |=> s_r.pri_cnt == '0)
    else $error("primary stretch not restarted");
  pri_hold_a: assert property (s_r.pri_cnt + `CNT_W'(1) < RST_TIMEOUT_CYC
                               |=> !primary_reset_n_o)
    else $error("primary reset released inside the timeout");
  sec_hold_a: assert property (s_r.sec_cnt + `CNT_W'(1) < RST_TIMEOUT_CYC
                               |=> !secondary_reset_n_o)
    else $error("secondary reset released inside the timeout");
  wd_short_bound_a: assert property (s_r.wd_short
                                     |-> s_r.wd_cnt < WD_SHORT_CYC)
    else $error("watchdog count ran past the short period");
  wd_long_bound_a: assert property (!s_r.wd_short
                                    |-> s_r.wd_cnt < WD_LONG_CYC)
    else $error("watchdog count ran past the long period");

endmodule

// [verilog/supervisor_defs.svh]
/*
 * timing constants for the reset supervisor.
 * assumes a 10 MHz reference clock (100 ns period).
 */
// Operation
// - secondary reset low while either supply flag is high or manual reset low.
// - secondary reset held low one full timeout after all its causes clear.
// - manual reset low forces reset, stretched one timeout after release.
// - floating manual reset input reads as high, never resetting.
// - watchdog kick level held past timeout expires timer, one reset timeout.
// - watchdog timer cleared during reset and on every kick edge.
// - after any reset, long 35 s watchdog timeout until first kick edge.
// - after first kick edge, 1.12 s short timeout; processor must keep toggling.
// - floating watchdog kick input disables watchdog entirely.
// - auxiliary undervoltage flag is a primary reset cause.
// - separate power-fail flag, independent of reset causes.
// - power-fail output low while flag active, released without stretch.
// - any cause recurring during the timeout restarts the count from zero.
// - primary reset asserts on every cause, then stretches for the timeout.
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

`define CLK_PERIOD_NS 100
`define WD_LONG_MS 35000
`define WD_SHORT_MS 1120
// least times round up
`define WD_LONG_CYC ((`WD_LONG_MS * 64'd1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WD_SHORT_CYC ((`WD_SHORT_MS * 64'd1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_TIMEOUT_CYC 2100000
`define CNT_W 32

`endif

// [verilog/supervisor_pkg.sv]
/*
 * types for the reset supervisor.
 * assumes supervisor_defs.svh is available on the include path.
 */
`include "supervisor_defs.svh"
package supervisor_pkg;

  typedef struct packed {
    logic primary_uv;
    logic secondary_uv;
    logic aux_uv;
    logic manual_reset_n;
    logic power_fail;
  } cause_t;

  typedef struct packed {
    logic [`CNT_W-1:0] pri_cnt;
    logic [`CNT_W-1:0] sec_cnt;
    logic [`CNT_W-1:0] wd_cnt;
    logic primary_reset_n;
    logic secondary_reset_n;
    logic power_fail_out_n;
    logic wd_short;
    logic kick_prev;
    logic wd_fire;
  } sup_state_t;

endpackage

// [dv/cpu_model.sv]
/* processor stand-in that toggles the watchdog kick line.
   assumes the supervisor's 10 MHz clock and its primary reset. */
`timescale 1ns/100ps
module cpu_model (
  // clock and control
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic reset_n_i,
  // kick pin
  output logic kick_o
);
  logic [7:0] cnt_r;
  initial begin
    kick_o = 1'b0;
    cnt_r = 8'h00;
  end
  // silent while held in reset; toggles every 30 cycles, inside the short window
  always @(posedge ref_clk_i) begin
    cnt_r <= (run_i && reset_n_i && cnt_r != 8'h1d) ? cnt_r + 8'h01 : 8'h00;
    if (run_i && reset_n_i && cnt_r == 8'h1d) kick_o <= ~kick_o;
  end
endmodule

// [dv/testbench.sv]
/* self-checking bench for the reset supervisor.
   assumes short counts: timeout 20, long watchdog 200, short 50. */
`timescale 1ns/100ps
module testbench;
  logic clk, rst_b, puv, suv, aux, power_fail_in, mr_n, mr_conn, kick, wd_conn, run;
  logic p_n, s_n, pf_n;
  int failures, cmp_count, cyc_n, n;
  supervisor_reset_watchdog #(.RST_TIMEOUT_CYC(32'h0000_0014),
    .WD_LONG_CYC(32'h0000_00c8), .WD_SHORT_CYC(32'h0000_0032)) uut (
    .ref_clk_i(clk), .rst_b_i(rst_b), .primary_uv_i(puv), .secondary_uv_i(suv),
    .aux_undervoltage_in_i(aux), .power_fail_in_i(power_fail_in), .manual_reset_n_i(mr_n),
    .manual_reset_conn_i(mr_conn), .watchdog_kick_in_i(kick),
    .watchdog_conn_i(wd_conn), .primary_reset_n_o(p_n),
    .secondary_reset_n_o(s_n), .power_fail_out_n_o(pf_n));
  cpu_model cpu (.ref_clk_i(clk), .run_i(run), .reset_n_i(p_n), .kick_o(kick));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task end_of_test;
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // count cycles until both resets show the wanted pair, giving up at 400
  task wt(input logic [1:0] want, output int k);
    k = 0;
    while ({p_n, s_n} !== want && k < 400) begin
      @(posedge clk);
      k++;
    end
  endtask
  task t_supply;
    suv <= 1'b1; cyc(5);
    check({p_n, s_n}, 2'b00);
    check(pf_n, 1);
    suv <= 1'b0; wt(2'b11, n);
    check(n >= 20 && n <= 26, 1);
    puv <= 1'b1; cyc(3); puv <= 1'b0; cyc(12);
    puv <= 1'b1; cyc(2); puv <= 1'b0; wt(2'b11, n);
    check(n >= 20 && n <= 26, 1);
  endtask
  task t_aux_pf;
    aux <= 1'b1; cyc(5);
    check({p_n, s_n}, 2'b01);
    aux <= 1'b0; wt(2'b11, n);
    check(n >= 20 && n <= 26, 1);
    power_fail_in <= 1'b1; cyc(4);
    check({pf_n, p_n}, 2'b01);
    power_fail_in <= 1'b0; cyc(4);
    check(pf_n, 1);
  endtask
  task t_manual;
    mr_n <= 1'b0; cyc(8);
    check({p_n, s_n}, 2'b11);
    mr_conn <= 1'b1; cyc(40);
    check({p_n, s_n}, 2'b00);
    mr_n <= 1'b1; wt(2'b11, n);
    check(n >= 20 && n <= 26, 1);
  endtask
  task t_watchdog;
    wd_conn <= 1'b1; wt(2'b01, n);
    check(n >= 195 && n <= 215, 1);
    wt(2'b11, n); run <= 1'b1; wt(2'b01, n);
    check(n, 400);
    run <= 1'b0; wt(2'b01, n);
    check(n >= 20 && n <= 60, 1);
    wt(2'b11, n); wt(2'b01, n);
    check(n >= 195 && n <= 215, 1);
    wt(2'b11, n); wd_conn <= 1'b0; wt(2'b01, n);
    check(n, 400);
  endtask
  // cuts a hang well past the expected 1500 or so cycles
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {rst_b, puv, suv, aux, power_fail_in, run, mr_conn, wd_conn} = 8'h00;
    {failures, cmp_count, cyc_n} = '0;
    mr_n = 1'b1;
    cyc(10); rst_b <= 1'b1;
    wt(2'b11, n);
    t_supply();
    t_aux_pf();
    t_manual();
    t_watchdog();
    end_of_test();
  end
endmodule
